/* bst_regs.svh */
// Constants of the boundary-scan test-operation engine
// Notes on behaviour
// - Toggle instruction: bypass bit, captures zero
// - Toggle: output cells invert rising, drive falling
// - Toggle: test mode, input cells hold
// - Control scan: control register kept at capture
// - Control bits 2..0 select five operations
// - Operation runs only run-test in idle
// - Cells 83..72 excluded; 83..80 drive enables
// - Run test: enables must agree per byte, else bypass; toggle ignores them
// - Control bits 20..3 mask active inputs
// - Mask one ignores pin, zero compresses it
// - Sample/toggle: capture inputs, toggle outputs
// - 36-bit pattern steps, shadows update falling
// - 36-bit signature compresses inputs each rising
// - 36-bit signature holds output shadows
// - 18-bit signature plus 18-bit pattern
// - 18-bit signature plus 18-bit up-count
// - Run test executes encoded operation in idle
// - Sample rising, drive outputs falling edge
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// Instruction opcodes seen on the instruction register
`define BST_IR_EXTEST 8'h00
`define BST_IR_SAMPLE 8'h82
`define BST_IR_INTEST 8'h03
`define BST_IR_CLAMP 8'h87
`define BST_IR_RUN 8'h09
`define BST_IR_READ_N 8'h0A
`define BST_IR_READ_T 8'h8B
`define BST_IR_SELFTEST 8'h0C
`define BST_IR_TOGGLE 8'h8D
`define BST_IR_CTRL_N 8'h8E
`define BST_IR_CTRL_T 8'h0F

// Boundary test control register layout
`define BST_CTL_W 21
`define BST_CTL_RESET 21'h000000
`define BST_CTL_OP_LSB 0
`define BST_CTL_OP_W 3
`define BST_CTL_MASK_LSB 3

// Boundary chain layout, cell positions
`define BST_CHAIN_W 84
`define BST_PINS 18
`define BST_A_IN 0
`define BST_A_OUT 18
`define BST_B_IN 36
`define BST_B_OUT 54
`define BST_EN_1AB 80
`define BST_EN_2AB 81
`define BST_EN_1BA 82
`define BST_EN_2BA 83

// Feedback tap positions of the LFSRs
`define BST_TAP36 24
`define BST_TAP18 10

`endif

/* bst_pkg.sv */
// Types shared by the boundary-scan test-operation engine
package bst_pkg;

  // Operation the cells perform on the current test clock edge
  typedef enum logic [6:0] {
    mode_idle = 7'h01,
    mode_toggle = 7'h02,
    mode_sample = 7'h04,
    mode_prpg36 = 7'h08,
    mode_psa36 = 7'h10,
    mode_signature_pattern_op = 7'h20,
    mode_psa_cnt = 7'h40
  } bst_mode_type;

endpackage

/* bst_engine.sv */
// Boundary-scan test-operation engine with control register and cells
`include "bst_regs.svh"

module bst_engine #(
  parameter int CNT_W = 16
) (
  // System clock domain
  input wire logic clock,
  input wire logic rst_n,
  // Test clock and tap controller state
  input wire logic tck,
  input wire logic tdi,
  input wire logic [7:0] ir_opcode,
  input wire logic tap_reset,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_run_idle,
  // Serial data out
  output logic tdo,
  output logic tdo_oe,
  // Device pins
  input wire logic [17:0] a_pin_in,
  input wire logic [17:0] b_pin_in,
  output logic [17:0] a_pin_out,
  output logic [17:0] a_pin_oe,
  output logic [17:0] b_pin_out,
  output logic [17:0] b_pin_oe,
  // Values applied to the core logic
  output logic [17:0] core_a_in,
  output logic [17:0] core_b_in,
  output logic test_mode,
  // Status seen from the system clock
  output logic sys_run_active,
  output logic [CNT_W-1:0] sys_step_count
);
  import bst_pkg::*;

  // Instruction selects the boundary chain in the scan path
  function automatic logic is_chain(input logic [7:0] ir);
    is_chain = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE) ||
               (ir == `BST_IR_INTEST) || (ir == `BST_IR_READ_N) ||
               (ir == `BST_IR_READ_T) || (ir == `BST_IR_SELFTEST);
  endfunction

  // Instruction selects the control register in the scan path
  function automatic logic is_ctrl(input logic [7:0] ir);
    is_ctrl = (ir == `BST_IR_CTRL_N) || (ir == `BST_IR_CTRL_T);
  endfunction

  // Opcode field to operation
  function automatic bst_mode_type op_decode(input logic [2:0] op);
    bst_mode_type m;
    m = mode_sample;
    unique case (op[1:0])
      2'b00: m = mode_sample;
      2'b01: m = mode_prpg36;
      2'b10: m = mode_psa36;
      2'b11: m = op[2] ? mode_psa_cnt : mode_signature_pattern_op;
    endcase
    return m;
  endfunction

  // Reset release synchronised to the test clock
  logic [1:0] rst_tck_q;
  logic rst_tck_n;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      rst_tck_q <= 2'h0;
    end else begin
      rst_tck_q <= {rst_tck_q[0], 1'b1};
    end
  end
  assign rst_tck_n = rst_tck_q[1];

  // Pin inputs pass two flip-flops before use
  logic [17:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      a_s1_q <= 18'h00000;
      a_s2_q <= 18'h00000;
      b_s1_q <= 18'h00000;
      b_s2_q <= 18'h00000;
    end else begin
      a_s1_q <= a_pin_in;
      a_s2_q <= a_s1_q;
      b_s1_q <= b_pin_in;
      b_s2_q <= b_s1_q;
    end
  end

  // Shift elements and shadow latches of every cell
  logic [`BST_CHAIN_W-1:0] bsr_q, bsr_d, shd_q, shd_d;
  logic [`BST_CTL_W-1:0] ctl_q, ctl_d;
  logic byp_q, byp_d;
  logic step_q, step_d;

  // Scan path selection and direction checks
  logic chain_sel, ctl_sel, dir_valid, a_to_b, run_active;
  logic in_instr_test;
  bst_mode_type mode;
  logic [17:0] mask, in_v, out_v, in_n, out_n, din;
  logic [35:0] wide;

  assign chain_sel = is_chain(ir_opcode);
  assign ctl_sel = is_ctrl(ir_opcode);
  // Each byte one direction, both bytes the same direction
  assign dir_valid = (shd_q[`BST_EN_1AB] != shd_q[`BST_EN_1BA]) &&
                     (shd_q[`BST_EN_2AB] != shd_q[`BST_EN_2BA]) &&
                     (shd_q[`BST_EN_1AB] == shd_q[`BST_EN_2AB]);
  assign a_to_b = !shd_q[`BST_EN_1AB];
  assign mask = ctl_q[`BST_CTL_MASK_LSB +: `BST_PINS];

  // Operation for this edge; run test with invalid direction falls back to bypass, toggle does not check it
  always_comb begin
    mode = mode_idle;
    if (tap_run_idle && ir_opcode == `BST_IR_TOGGLE) begin
      mode = mode_toggle;
    end else if (tap_run_idle && ir_opcode == `BST_IR_RUN && dir_valid) begin
      mode = op_decode(ctl_q[`BST_CTL_OP_LSB +: `BST_CTL_OP_W]);
    end
  end
  assign run_active = (mode != mode_idle);

  // Test mode follows the instruction; bypass fallback is normal mode
  assign in_instr_test = (ir_opcode == `BST_IR_TOGGLE) ||
                         (ir_opcode == `BST_IR_CTRL_T) ||
                         (ir_opcode == `BST_IR_EXTEST) ||
                         (ir_opcode == `BST_IR_INTEST) ||
                         (ir_opcode == `BST_IR_CLAMP) ||
                         (ir_opcode == `BST_IR_READ_T) ||
                         (ir_opcode == `BST_IR_RUN && dir_valid);

  // Active input and output cells per direction; control cells left out
  always_comb begin
    if (a_to_b) begin
      in_v = bsr_q[`BST_A_IN +: `BST_PINS];
      out_v = bsr_q[`BST_B_OUT +: `BST_PINS];
      din = a_s2_q & ~mask;
    end else begin
      in_v = bsr_q[`BST_B_IN +: `BST_PINS];
      out_v = bsr_q[`BST_A_OUT +: `BST_PINS];
      din = b_s2_q & ~mask;
    end
  end

  // Next cell contents for each operation
  always_comb begin
    in_n = in_v;
    out_n = out_v;
    wide = {out_v, in_v};
    unique case (mode)
      mode_idle: begin
        in_n = in_v;
      end
      mode_toggle: begin
        out_n = ~out_v;
      end
      mode_sample: begin
        in_n = a_to_b ? a_s2_q : b_s2_q;
        out_n = ~out_v;
      end
      mode_prpg36: begin
        wide = {wide[34:0], wide[35] ^ wide[`BST_TAP36]};
        {out_n, in_n} = wide;
      end
      mode_psa36: begin
        wide = {wide[34:0], wide[35] ^ wide[`BST_TAP36]} ^ {18'h00000, din};
        {out_n, in_n} = wide;
      end
      mode_signature_pattern_op: begin
        in_n = {in_v[16:0], in_v[17] ^ in_v[`BST_TAP18]} ^ din;
        out_n = {out_v[16:0], out_v[17] ^ out_v[`BST_TAP18]};
      end
      mode_psa_cnt: begin
        in_n = {in_v[16:0], in_v[17] ^ in_v[`BST_TAP18]} ^ din;
        out_n = out_v + 18'h00001;
      end
    endcase
  end

  // Shift elements: chain scan for seeding and readout, else run op
  always_comb begin
    bsr_d = bsr_q;
    if (tap_shift_dr && chain_sel) begin
      bsr_d = {tdi, bsr_q[`BST_CHAIN_W-1:1]};
    end else if (run_active) begin
      if (a_to_b) begin
        bsr_d[`BST_A_IN +: `BST_PINS] = in_n;
        bsr_d[`BST_B_OUT +: `BST_PINS] = out_n;
      end else begin
        bsr_d[`BST_B_IN +: `BST_PINS] = in_n;
        bsr_d[`BST_A_OUT +: `BST_PINS] = out_n;
      end
    end
  end

  // Control register keeps its value at capture, shifts in Shift-DR
  always_comb begin
    ctl_d = ctl_q;
    if (tap_reset) begin
      ctl_d = `BST_CTL_RESET;
    end else if (ctl_sel && tap_shift_dr) begin
      ctl_d = {tdi, ctl_q[`BST_CTL_W-1:1]};
    end
  end

  // Bypass bit captures zero for every bypass-path instruction
  always_comb begin
    byp_d = byp_q;
    if (!chain_sel && !ctl_sel && tap_capture_dr) begin
      byp_d = 1'b0;
    end else if (!chain_sel && !ctl_sel && tap_shift_dr) begin
      byp_d = tdi;
    end
  end

  // Step toggles once per executed operation edge
  assign step_d = step_q ^ run_active;

  // Rising-edge state of the test clock domain
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bsr_q <= '0;
      ctl_q <= `BST_CTL_RESET;
      byp_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      bsr_q <= bsr_d;
      ctl_q <= ctl_d;
      byp_q <= byp_d;
      step_q <= step_d;
    end
  end

  // Shadow latches update on the falling edge
  logic upd_in, upd_out;
  logic tdo_d, tdo_oe_d;

  assign upd_in = (mode != mode_toggle);
  assign upd_out = (mode != mode_psa36);

  always_comb begin
    shd_d = shd_q;
    if (tap_update_dr && chain_sel) begin
      shd_d = bsr_q;
    end else if (run_active) begin
      if (upd_in) begin
        shd_d[`BST_A_IN +: `BST_PINS] = bsr_q[`BST_A_IN +: `BST_PINS];
        shd_d[`BST_B_IN +: `BST_PINS] = bsr_q[`BST_B_IN +: `BST_PINS];
      end
      if (upd_out) begin
        shd_d[`BST_A_OUT +: `BST_PINS] = bsr_q[`BST_A_OUT +: `BST_PINS];
        shd_d[`BST_B_OUT +: `BST_PINS] = bsr_q[`BST_B_OUT +: `BST_PINS];
      end
    end
  end

  // Serial output changes on the falling edge, enabled while shifting
  always_comb begin
    if (chain_sel) begin
      tdo_d = bsr_q[0];
    end else if (ctl_sel) begin
      tdo_d = ctl_q[0];
    end else begin
      tdo_d = byp_q;
    end
    // Enabled from the capture fall so the first bit is driven when read
    tdo_oe_d = tap_shift_dr || tap_capture_dr;
  end

  always_ff @(negedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      shd_q <= {4'hF, {(`BST_CHAIN_W-4){1'b0}}};
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      shd_q <= shd_d;
      tdo <= tdo_d;
      tdo_oe <= tdo_oe_d;
      test_mode <= in_instr_test;
    end
  end

  // Pins and core driven from shadow latches; enables gate each byte
  assign a_pin_out = shd_q[`BST_A_OUT +: `BST_PINS];
  assign b_pin_out = shd_q[`BST_B_OUT +: `BST_PINS];
  assign core_a_in = shd_q[`BST_A_IN +: `BST_PINS];
  assign core_b_in = shd_q[`BST_B_IN +: `BST_PINS];
  assign b_pin_oe = {{9{test_mode && !shd_q[`BST_EN_2AB]}},
                     {9{test_mode && !shd_q[`BST_EN_1AB]}}};
  assign a_pin_oe = {{9{test_mode && !shd_q[`BST_EN_2BA]}},
                     {9{test_mode && !shd_q[`BST_EN_1BA]}}};

  // Crossing to the system clock: level by two flops, step by toggle
  logic run_lvl_q, run_lvl_d;
  logic run_s1_q, run_s2_q;
  logic stp_s1_q, stp_s2_q, stp_s3_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // Level is held in a flop so no gate feeds the synchroniser
  assign run_lvl_d = run_active;

  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      run_lvl_q <= 1'b0;
    end else begin
      run_lvl_q <= run_lvl_d;
    end
  end

  // A held level survives a stopped test clock, which a pulse would not
  always_comb begin
    cnt_d = cnt_q;
    if (stp_s2_q != stp_s3_q) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      stp_s1_q <= 1'b0;
      stp_s2_q <= 1'b0;
      stp_s3_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      run_s1_q <= run_lvl_q;
      run_s2_q <= run_s1_q;
      stp_s1_q <= step_q;
      stp_s2_q <= stp_s1_q;
      stp_s3_q <= stp_s2_q;
      cnt_q <= cnt_d;
    end
  end

  assign sys_run_active = run_s2_q;
  assign sys_step_count = cnt_q;

endmodule

/* bst_engine_props.sv */
// Port checks of the boundary-scan test-operation engine
`include "bst_regs.svh"
module bst_engine_props #(
  parameter int CNT_W = 16
) (
  // Clocks and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  // Access port state
  input wire logic [7:0] ir_opcode,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_run_idle,
  // Observed outputs
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [17:0] a_pin_oe,
  input wire logic [17:0] b_pin_out,
  input wire logic [17:0] b_pin_oe,
  input wire logic [17:0] core_a_in,
  input wire logic test_mode,
  input wire logic sys_run_active
);
  logic tog;
  logic run_off;

  // Toggle steps with B outputs active; run-test edges outside idle
  assign tog = tap_run_idle && ir_opcode == `BST_IR_TOGGLE && b_pin_oe[0];
  assign run_off = !tap_run_idle && ir_opcode == `BST_IR_RUN;

  sequence tog_twice;
    tog ##1 tog;
  endsequence

  chk_toggle_invert: assert property (
    @(posedge tck) disable iff (!rst_n)
    tog_twice |=> b_pin_out == ~$past(b_pin_out))
    else $error("outputs did not invert");
  chk_core_hold: assert property (
    @(posedge tck) disable iff (!rst_n) tog_twice |=> $stable(core_a_in))
    else $error("core inputs moved while toggling");
  chk_bypass_zero: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap_capture_dr && ir_opcode inside {`BST_IR_TOGGLE, `BST_IR_RUN}
    |=> !tdo)
    else $error("bypass bit not zero");
  chk_tdo_enable: assert property (
    @(negedge tck) disable iff (!rst_n) tap_shift_dr [*2] |-> tdo_oe)
    else $error("serial out not driven in shift");
  chk_tdo_first: assert property (
    @(negedge tck) disable iff (!rst_n) tap_capture_dr |=> tdo_oe)
    else $error("first serial bit not driven");
  chk_oe_needs_test: assert property (
    @(posedge tck) disable iff (!rst_n)
    (|a_pin_oe || |b_pin_oe) |-> test_mode)
    else $error("pins driven outside test mode");
  chk_oe_per_byte: assert property (
    @(posedge tck) disable iff (!rst_n)
    a_pin_oe[8:0] inside {9'h000, 9'h1FF}
    && a_pin_oe[17:9] inside {9'h000, 9'h1FF}
    && b_pin_oe[8:0] inside {9'h000, 9'h1FF}
    && b_pin_oe[17:9] inside {9'h000, 9'h1FF})
    else $error("byte enables split");
  chk_idle_only: assert property (
    @(posedge tck) disable iff (!rst_n) run_off [*2] |-> $stable(b_pin_out))
    else $error("outputs moved outside idle");
  chk_sys_active: assert property (
    @(posedge clock) disable iff (!rst_n)
    (tap_run_idle && test_mode) [*3] |-> ##[0:3] sys_run_active)
    else $error("run status not seen");
endmodule

bind bst_engine bst_engine_props #(.CNT_W(CNT_W)) u_props (
  .clock(clock), .rst_n(rst_n), .tck(tck), .ir_opcode(ir_opcode),
  .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr),
  .tap_run_idle(tap_run_idle), .tdo(tdo), .tdo_oe(tdo_oe),
  .a_pin_oe(a_pin_oe), .b_pin_out(b_pin_out), .b_pin_oe(b_pin_oe),
  .core_a_in(core_a_in), .test_mode(test_mode),
  .sys_run_active(sys_run_active)
);

/* bst_tap_model.sv */
// Behavioural scan controller standing at the test access port
module bst_tap_model (
  // Access port levels
  output logic tck,
  output logic tdi,
  output logic [7:0] ir_opcode,
  output logic tap_reset,
  output logic tap_capture_dr,
  output logic tap_shift_dr,
  output logic tap_update_dr,
  output logic tap_run_idle,
  // Serial return
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels; bypass-class instruction until told otherwise
  initial begin
    {tck, tdi, tap_reset, tap_capture_dr} = '0;
    {tap_shift_dr, tap_update_dr, tap_run_idle} = '0;
    ir_opcode = 8'h84;
  end

  // Clock stands low between frames; levels move 1 ns after falls
  task automatic pulse(input int n);
    repeat (n) begin
      #15 tck = 1'b1;
      #16 tck = 1'b0;
      #1;
    end
  endtask

  // Capture, shift LSB first, then update
  task automatic scan(input logic [7:0] ir, input int len,
      input logic [83:0] din, output logic [83:0] dout);
    ir_opcode = ir;
    dout = '0;
    tap_capture_dr = 1'b1;
    pulse(1);
    tap_capture_dr = 1'b0;
    tap_shift_dr = 1'b1;
    for (int i = 0; i < len; i++) begin
      tdi = din[i];
      dout[i] = tdo;
      pulse(1);
    end
    tap_shift_dr = 1'b0;
    tap_update_dr = 1'b1;
    pulse(1);
    tap_update_dr = 1'b0;
  endtask

  // Stay in idle for n steps, then two edges outside idle
  task automatic run(input logic [7:0] ir, input int n);
    ir_opcode = ir;
    tap_run_idle = 1'b1;
    pulse(n);
    tap_run_idle = 1'b0;
    pulse(2);
  endtask

  // One edge in the reset state
  task automatic clear();
    tap_reset = 1'b1;
    pulse(1);
    tap_reset = 1'b0;
  endtask
endmodule

/* testbench.sv */
// Self-checking bench of the boundary-scan test-operation engine
`include "bst_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); \
  end \
end
  logic clock, rst_n, tck, tdi, tap_reset, tdo, tdo_oe, test_mode;
  logic tap_capture_dr, tap_shift_dr, tap_update_dr, tap_run_idle;
  logic sys_run_active;
  logic [7:0] ir_opcode;
  logic [17:0] a_pin_in, b_pin_in, a_pin_out, a_pin_oe, b_pin_out;
  logic [17:0] b_pin_oe, core_a_in, core_b_in;
  logic [15:0] sys_step_count;
  int n_errors = 0;
  int checks_done = 0;
  int ops[9] = '{0, 4, 1, 5, 2, 6, 3, 7, 8};

  bst_engine #(.CNT_W(16)) u_bst_engine (
    .clock(clock), .rst_n(rst_n), .tck(tck), .tdi(tdi),
    .ir_opcode(ir_opcode), .tap_reset(tap_reset),
    .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr),
    .tap_update_dr(tap_update_dr), .tap_run_idle(tap_run_idle),
    .tdo(tdo), .tdo_oe(tdo_oe), .a_pin_in(a_pin_in), .b_pin_in(b_pin_in),
    .a_pin_out(a_pin_out), .a_pin_oe(a_pin_oe), .b_pin_out(b_pin_out),
    .b_pin_oe(b_pin_oe), .core_a_in(core_a_in), .core_b_in(core_b_in),
    .test_mode(test_mode), .sys_run_active(sys_run_active),
    .sys_step_count(sys_step_count)
  );
  bst_tap_model u_tap (
    .tck(tck), .tdi(tdi), .ir_opcode(ir_opcode), .tap_reset(tap_reset),
    .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr),
    // A released serial line reads as the inverse of the last bit
    .tap_update_dr(tap_update_dr), .tap_run_idle(tap_run_idle),
    .tdo(tdo_oe ? tdo : !tdo)
  );

  // Active cells {out, in} after one step; op 8 is the toggle instruction
  function automatic logic [35:0] step(input int op, input logic [35:0] v,
      input logic [17:0] pin, input logic [17:0] m);
    logic [17:0] o;
    logic [17:0] i;
    o = v[35:18];
    i = v[17:0];
    case (op)
      8: o = ~o;
      0, 4: begin o = ~o; i = pin; end
      1, 5: return {v[34:0], v[35] ^ v[24]};
      2, 6: return {v[34:0], v[35] ^ v[24]} ^ {18'h0, pin & ~m};
      default: begin
        i = {i[16:0], i[17] ^ i[10]} ^ (pin & ~m);
        o = (op == 3) ? {o[16:0], o[17] ^ o[10]} : o + 18'h1;
      end
    endcase
    return {o, i};
  endfunction

  // Seed the chain, load the control register, run, compare the pins
  task automatic run_op(input int op, input logic [3:0] en, input int n);
    logic [83:0] c;
    logic [83:0] d;
    logic [35:0] v;
    logic [17:0] m;
    logic [17:0] o0;
    logic ab;
    ab = en[3];
    m = 18'($urandom);
    a_pin_in = 18'($urandom);
    b_pin_in = 18'($urandom);
    v = 36'({$urandom, $urandom}) | 36'h1;
    c = 84'({$urandom, $urandom, $urandom});
    c[83:72] = {en, 8'h00};
    if (ab) begin
      c[17:0] = v[17:0];
      c[71:54] = v[35:18];
    end else begin
      c[53:36] = v[17:0];
      c[35:18] = v[35:18];
    end
    o0 = v[35:18];
    u_tap.scan(`BST_IR_SAMPLE, 84, c, d);
    u_tap.scan(`BST_IR_CTRL_N, 21, 84'({m, op[2:0]}), d);
    u_tap.run(op == 8 ? `BST_IR_TOGGLE : `BST_IR_RUN, n);
    for (int k = 0; k < n; k++) v = step(op, v, ab ? a_pin_in : b_pin_in, m);
    if (en != 4'b1100 && en != 4'b0011) begin
      `CHK(test_mode, 1'b0)
      `CHK({a_pin_oe, b_pin_oe}, 36'h0)
    end else begin
      `CHK(test_mode, 1'b1)
      `CHK(ab ? core_a_in : core_b_in, v[17:0])
      `CHK(ab ? b_pin_out : a_pin_out, op[1:0] == 2 ? o0 : v[35:18])
      `CHK(ab ? b_pin_oe : a_pin_oe, 18'h3FFFF)
    end
    $display("test op %0d enables %b done", op, en);
  endtask

  // Verdict; also reached from the watchdog
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // System clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Main sequence: reset with test clock edges, scans, then all operations
  initial begin
    logic [83:0] d;
    logic [83:0] w;
    rst_n = 1'b0;
    a_pin_in = '0;
    b_pin_in = '0;
    void'($urandom(46419));
    u_tap.pulse(3);
    repeat (5) @(posedge clock);
    #5 rst_n = 1'b1;
    u_tap.pulse(3);
    `CHK({a_pin_oe, b_pin_oe}, 36'h0)
    w = 84'(21'($urandom));
    u_tap.scan(`BST_IR_TOGGLE, 2, 84'h3, d);
    `CHK(d[1:0], 2'b10)
    u_tap.scan(`BST_IR_CTRL_N, 21, w, d);
    `CHK(d[20:0], 21'h0)
    u_tap.scan(`BST_IR_CTRL_T, 21, 84'h0, d);
    `CHK(d[20:0], w[20:0])
    u_tap.clear();
    u_tap.scan(`BST_IR_CTRL_N, 21, w, d);
    `CHK(d[20:0], 21'h0)
    $display("test register scans done");
    for (int k = 0; k < 9; k++) begin
      run_op(ops[k], 4'b1100, 3 + k);
      run_op(ops[k], 4'b0011, 5);
    end
    run_op(7, 4'b0000, 4);
    run_op(7, 4'b1001, 4);
    `CHK(sys_step_count != 16'h0, 1'b1)
    summarize();
  end

  // Watchdog far above the roughly 80 us the tests take
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
endmodule
